// [logic/enc_i2c_defs.svh]
// Offsets, field positions, command codes and timing for the encoder register slave
`ifndef ENC_I2C_DEFS_SVH
`define ENC_I2C_DEFS_SVH
`define I2C_DEV_ADDR 7'h36
`define BYTE_BITS 4'h8
`define REG_ZCOUNT 8'h00
`define REG_ZERO_HI 8'h01
`define REG_ZERO_LO 8'h02
`define REG_SETUP_HI 8'h07
`define REG_SETUP_LO 8'h08
`define REG_QRES 8'h09
`define REG_PRESS 8'h0A
`define REG_FLAGS 8'h0B
`define REG_RAW_HI 8'h0C
`define REG_RAW_LO 8'h0D
`define REG_ANG_HI 8'h0E
`define REG_ANG_LO 8'h0F
`define REG_GAIN 8'h1A
`define REG_MAG_HI 8'h1B
`define REG_MAG_LO 8'h1C
`define REG_CMD 8'hFF
`define CMD_BURN_ZERO 8'h80
`define CMD_BURN_SETUP 8'h40
`define CMD_RELOAD_A 8'h01
`define CMD_RELOAD_B 8'h11
`define CMD_RELOAD_C 8'h10
`define ZERO_BURN_MAX 2'h3
`define FLAG_DETECT_BIT 5
`define FLAG_WEAK_BIT 4
`define FLAG_STRONG_BIT 3
`define APPLY_DELAY_US 1000
`define SYS_CLK_KHZ 10000
`define ANGLE_MAX 12'hFFF
`define ANGLE_WRAP_HYSTERESIS_FIELD 12'h00A
`define SLOW_FILTER_16X 2'h0
`define POWER_NORMAL 2'h0
`define QRES_MAX_POS 12'h800
`define QRES_MIN_POS 12'h008
`endif

// [logic/enc_i2c_pkg.sv]
// Types shared by the encoder register slave
package enc_i2c_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK_ADDR = 3'h3,
    ST_RX = 3'h2,
    ST_ACK_RX = 3'h6,
    ST_TX = 3'h7,
    ST_ACK_TX = 3'h5
  } bus_state_t;

  typedef enum logic [1:0] {
    RL_IDLE = 2'h0,
    RL_ONE = 2'h1,
    RL_TWO = 2'h3
  } reload_t;

  typedef struct packed {
    logic auto_sleep_enable;
    logic [2:0] fast_filter_threshold;
    logic [1:0] slow_filter_field;
    logic [1:0] hysteresis_field;
    logic [1:0] power_state_field;
  } setup_word_t;

  typedef struct packed {
    logic [11:0] zero_position;
    setup_word_t setup_word;
    logic [3:0] quadrature_resolution;
    logic [7:0] press_threshold;
  } cfg_t;

  typedef struct packed {
    logic [1:0] slow_filter;
    logic [4:0] fast_threshold_lsb;
    logic [11:0] positions;
  } decoded_t;
endpackage

// [logic/i2c_config_register_slave.sv]
// Two-wire register slave and settings store of the rotary encoder
`timescale 1ns/100ps
`include "enc_i2c_defs.svh"
// Summary of operation
// - Answer only to bus address 0x36; direction bit low writes, high reads.
// - Acknowledge a matching address byte for both reads and writes.
// - First byte of a write is the word address, loaded into the pointer.
// - Acknowledge the word address if valid, otherwise leave data line high.
// - Discard and refuse data to invalid addresses; acknowledge valid ones, storing only zero, setup, resolution and press bytes.
// - Pointer increments after every data byte, valid or not, except reads at the high bytes below.
// - Reads start at the current pointer, the last one held if none written.
// - Data bytes travel most significant bit first in both directions.
// - Zero position is twelve bits split over two registers.
// - Setup bits 1:0 pick power state, bits 3:2 pick hysteresis.
// - Setup bits 9:8 pick slow filter; 16x forced in low-power states.
// - Setup bits 12:10 pick fast-filter threshold from the fixed table.
// - Setup bit 13 enables automatic entry into the third low-power state.
// - Resolution codes 0 to 7 give 8 to 1024 positions, others 2048.
// - Scaled angle holds a 10-LSB hysteresis across the rotation wrap point.
// - Status shows gain-minimum, gain-maximum and magnet-detected flags.
// - Command 0x80 burns zero position, at most 3 times, magnet present only.
// - Command 0x40 burns the settings once in the device life.
// - Commands 0x01, 0x11, 0x10 in order reload the burnt content.
// - At power-up registers load burnt values; unburnt bits read zero.
// - New settings reach the outputs no earlier than 1 ms after the write.
// - Invalid addresses read as zero while the pointer still advances.
// - Reads at raw, scaled or magnitude high bytes do not advance pointer.
module i2c_config_register_slave
  import enc_i2c_pkg::*;
#(
  parameter int APPLY_CYCLES = `APPLY_DELAY_US * `SYS_CLK_KHZ / 1000
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [11:0] raw_angle_in,
  input wire logic [11:0] scaled_angle_in,
  input wire logic [7:0] gain_level_in,
  input wire logic [11:0] magnitude_in,
  input wire logic magnet_detected_flag_in,
  input wire logic field_weak_flag_in,
  input wire logic field_strong_flag_in,
  output cfg_t settings_out,
  output decoded_t decoded_out,
  output logic [11:0] scaled_angle_out,
  output logic [1:0] zero_burn_count_out,
  output logic apply_pending_out
);
  localparam int CW = $clog2(APPLY_CYCLES + 1);

  if (APPLY_CYCLES < 1) begin : g_bad_apply
    $error("APPLY_CYCLES must be at least one");
  end

  function automatic logic addr_valid(input logic [7:0] a);
    case (a)
      `REG_ZCOUNT, `REG_ZERO_HI, `REG_ZERO_LO, `REG_SETUP_HI, `REG_SETUP_LO,
      `REG_QRES, `REG_PRESS, `REG_FLAGS, `REG_RAW_HI, `REG_RAW_LO, `REG_ANG_HI,
      `REG_ANG_LO, `REG_GAIN, `REG_MAG_HI, `REG_MAG_LO, `REG_CMD: addr_valid = 1'b1;
      default: addr_valid = 1'b0;
    endcase
  endfunction

  function automatic logic [4:0] fast_lsb(input logic [2:0] code);
    case (code)
      3'h1: fast_lsb = 5'h06;
      3'h2: fast_lsb = 5'h07;
      3'h3: fast_lsb = 5'h09;
      3'h4: fast_lsb = 5'h12;
      3'h5: fast_lsb = 5'h15;
      3'h6: fast_lsb = 5'h18;
      3'h7: fast_lsb = 5'h0A;
      default: fast_lsb = 5'h00;
    endcase
  endfunction

  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic scl_meta_ff, scl_sync_ff, scl_prev_ff;
  logic sda_meta_ff, sda_sync_ff, sda_prev_ff;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_meta_ff <= scl_in;
      scl_sync_ff <= scl_meta_ff;
      scl_prev_ff <= scl_sync_ff;
      sda_meta_ff <= sda_in;
      sda_sync_ff <= sda_meta_ff;
      sda_prev_ff <= sda_sync_ff;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_sync_ff & ~scl_prev_ff;
  assign scl_fall = ~scl_sync_ff & scl_prev_ff;
  assign start_det = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
  assign stop_det = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;

  // ==========================================================
  // Register state declarations
  cfg_t cfg_ff, nxt_cfg, otp_ff, nxt_otp, applied_ff, nxt_applied;
  decoded_t decoded_ff, nxt_decoded;
  logic [1:0] zcount_ff, nxt_zcount;
  logic burned_ff, nxt_burned, loaded_ff, nxt_loaded;
  reload_t reload_ff, nxt_reload;
  logic [CW-1:0] apply_cnt_ff, nxt_apply_cnt;
  logic [11:0] angle_ff, nxt_angle;
  logic [7:0] tx_byte;

  // ==========================================================
  // Bus state machine
  bus_state_t state_ff, nxt_state;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] shift_ff, nxt_shift, ptr_ff, nxt_ptr;
  logic rw_ff, nxt_rw, first_ff, nxt_first, sda_oe_ff, nxt_sda_oe;
  logic wr_stb, sticky;

  assign sticky = (ptr_ff == `REG_RAW_HI) || (ptr_ff == `REG_ANG_HI) || (ptr_ff == `REG_MAG_HI);

  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_rw = rw_ff;
    nxt_first = first_ff;
    nxt_sda_oe = sda_oe_ff;
    wr_stb = 1'b0;
    if (start_det) begin
      nxt_state = ST_ADDR;
      nxt_bit_cnt = 4'h0;
      nxt_sda_oe = 1'b0;
    end else if (stop_det) begin
      nxt_state = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else begin
      case (state_ff)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_sync_ff};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == `BYTE_BITS) begin
            nxt_bit_cnt = 4'h0;
            if (state_ff == ST_ADDR) begin
              if (shift_ff[7:1] == `I2C_DEV_ADDR) begin
                nxt_state = ST_ACK_ADDR;
                nxt_rw = shift_ff[0];
                nxt_sda_oe = 1'b1;
              end else begin
                nxt_state = ST_IDLE;
              end
            end else if (first_ff) begin
              nxt_ptr = shift_ff;
              nxt_first = 1'b0;
              nxt_sda_oe = addr_valid(shift_ff);
              nxt_state = ST_ACK_RX;
            end else begin
              wr_stb = addr_valid(ptr_ff);
              nxt_sda_oe = addr_valid(ptr_ff);
              nxt_ptr = ptr_ff + 8'h01;
              nxt_state = ST_ACK_RX;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_ff) begin
              nxt_shift = tx_byte;
              nxt_sda_oe = ~tx_byte[7];
              nxt_state = ST_TX;
            end else begin
              nxt_first = 1'b1;
              nxt_sda_oe = 1'b0;
              nxt_state = ST_RX;
            end
          end
        end
        ST_ACK_RX: begin
          if (scl_fall) begin
            nxt_sda_oe = 1'b0;
            nxt_state = ST_RX;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_ff == `BYTE_BITS) begin
              nxt_bit_cnt = 4'h0;
              nxt_sda_oe = 1'b0;
              nxt_state = ST_ACK_TX;
              if (!sticky) begin
                nxt_ptr = ptr_ff + 8'h01;
              end
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sda_oe = ~shift_ff[6];
            end
          end
        end
        ST_ACK_TX: begin
          if (scl_rise && sda_sync_ff) begin
            nxt_state = ST_IDLE;
          end else if (scl_fall) begin
            nxt_shift = tx_byte;
            nxt_sda_oe = ~tx_byte[7];
            nxt_state = ST_TX;
          end
        end
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      rw_ff <= nxt_rw;
      first_ff <= nxt_first;
      sda_oe_ff <= nxt_sda_oe;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe_ff;

  // ==========================================================
  // Read data selection
  always_comb begin
    tx_byte = 8'h00;
    case (ptr_ff)
      `REG_ZCOUNT: tx_byte = {6'h00, zcount_ff};
      `REG_ZERO_HI: tx_byte = {4'h0, cfg_ff.zero_position[11:8]};
      `REG_ZERO_LO: tx_byte = cfg_ff.zero_position[7:0];
      `REG_SETUP_HI: tx_byte = {2'h0, cfg_ff.setup_word.auto_sleep_enable,
        cfg_ff.setup_word.fast_filter_threshold, cfg_ff.setup_word.slow_filter_field};
      `REG_SETUP_LO: tx_byte = {4'h0, cfg_ff.setup_word.hysteresis_field,
        cfg_ff.setup_word.power_state_field};
      `REG_QRES: tx_byte = {4'h0, cfg_ff.quadrature_resolution};
      `REG_PRESS: tx_byte = cfg_ff.press_threshold;
      `REG_FLAGS: begin
        tx_byte[`FLAG_DETECT_BIT] = magnet_detected_flag_in;
        tx_byte[`FLAG_WEAK_BIT] = field_weak_flag_in;
        tx_byte[`FLAG_STRONG_BIT] = field_strong_flag_in;
      end
      `REG_RAW_HI: tx_byte = {4'h0, raw_angle_in[11:8]};
      `REG_RAW_LO: tx_byte = raw_angle_in[7:0];
      `REG_ANG_HI: tx_byte = {4'h0, angle_ff[11:8]};
      `REG_ANG_LO: tx_byte = angle_ff[7:0];
      `REG_GAIN: tx_byte = gain_level_in;
      `REG_MAG_HI: tx_byte = {4'h0, magnitude_in[11:8]};
      `REG_MAG_LO: tx_byte = magnitude_in[7:0];
      default: tx_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // Settings, one-time store, commands and apply delay
  logic angle_hold;
  assign angle_hold =
    (angle_ff > `ANGLE_MAX - `ANGLE_WRAP_HYSTERESIS_FIELD && scaled_angle_in < `ANGLE_WRAP_HYSTERESIS_FIELD)
    || (angle_ff < `ANGLE_WRAP_HYSTERESIS_FIELD && scaled_angle_in > `ANGLE_MAX - `ANGLE_WRAP_HYSTERESIS_FIELD);

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_otp = otp_ff;
    nxt_zcount = zcount_ff;
    nxt_burned = burned_ff;
    nxt_reload = reload_ff;
    nxt_loaded = 1'b1;
    nxt_applied = applied_ff;
    nxt_apply_cnt = apply_cnt_ff;
    nxt_angle = angle_hold ? angle_ff : scaled_angle_in;
    nxt_decoded.slow_filter = (applied_ff.setup_word.power_state_field != `POWER_NORMAL) ?
      `SLOW_FILTER_16X : applied_ff.setup_word.slow_filter_field;
    nxt_decoded.fast_threshold_lsb =
      fast_lsb(applied_ff.setup_word.fast_filter_threshold);
    nxt_decoded.positions = applied_ff.quadrature_resolution[3] ? `QRES_MAX_POS :
      12'(`QRES_MIN_POS << applied_ff.quadrature_resolution[2:0]);
    if (apply_cnt_ff != '0) begin
      nxt_apply_cnt = apply_cnt_ff - CW'(1);
      if (apply_cnt_ff == CW'(1)) begin
        nxt_applied = cfg_ff;
      end
    end
    if (!loaded_ff) begin
      nxt_cfg = otp_ff;
      nxt_apply_cnt = CW'(APPLY_CYCLES);
    end else if (wr_stb) begin
      nxt_apply_cnt = CW'(APPLY_CYCLES);
      case (ptr_ff)
        `REG_ZERO_HI: nxt_cfg.zero_position[11:8] = shift_ff[3:0];
        `REG_ZERO_LO: nxt_cfg.zero_position[7:0] = shift_ff;
        `REG_SETUP_HI: begin
          nxt_cfg.setup_word.auto_sleep_enable = shift_ff[5];
          nxt_cfg.setup_word.fast_filter_threshold = shift_ff[4:2];
          nxt_cfg.setup_word.slow_filter_field = shift_ff[1:0];
        end
        `REG_SETUP_LO: begin
          nxt_cfg.setup_word.hysteresis_field = shift_ff[3:2];
          nxt_cfg.setup_word.power_state_field = shift_ff[1:0];
        end
        `REG_QRES: nxt_cfg.quadrature_resolution = shift_ff[3:0];
        `REG_PRESS: nxt_cfg.press_threshold = shift_ff;
        `REG_CMD: begin
          nxt_reload = RL_IDLE;
          case (shift_ff)
            `CMD_BURN_ZERO: begin
              if (magnet_detected_flag_in && zcount_ff != `ZERO_BURN_MAX) begin
                nxt_otp.zero_position = cfg_ff.zero_position;
                nxt_zcount = zcount_ff + 2'h1;
              end
            end
            `CMD_BURN_SETUP: begin
              if (!burned_ff) begin
                nxt_otp.setup_word = cfg_ff.setup_word;
                nxt_otp.quadrature_resolution = cfg_ff.quadrature_resolution;
                nxt_otp.press_threshold = cfg_ff.press_threshold;
                nxt_burned = 1'b1;
              end
            end
            `CMD_RELOAD_A: nxt_reload = RL_ONE;
            `CMD_RELOAD_B: nxt_reload = (reload_ff == RL_ONE) ? RL_TWO : RL_IDLE;
            `CMD_RELOAD_C: begin
              if (reload_ff == RL_TWO) begin
                nxt_cfg = otp_ff;
              end
            end
            default: nxt_reload = RL_IDLE;
          endcase
        end
        default: nxt_cfg = cfg_ff;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= '0;
      otp_ff <= '0;
      applied_ff <= '0;
      decoded_ff <= '0;
      zcount_ff <= 2'h0;
      burned_ff <= 1'b0;
      reload_ff <= RL_IDLE;
      loaded_ff <= 1'b0;
      apply_cnt_ff <= '0;
      angle_ff <= 12'h000;
    end else begin
      cfg_ff <= nxt_cfg;
      otp_ff <= nxt_otp;
      applied_ff <= nxt_applied;
      decoded_ff <= nxt_decoded;
      zcount_ff <= nxt_zcount;
      burned_ff <= nxt_burned;
      reload_ff <= nxt_reload;
      loaded_ff <= nxt_loaded;
      apply_cnt_ff <= nxt_apply_cnt;
      angle_ff <= nxt_angle;
    end
  end

  assign settings_out = applied_ff;
  assign decoded_out = decoded_ff;
  assign scaled_angle_out = angle_ff;
  assign zero_burn_count_out = zcount_ff;
  assign apply_pending_out = (apply_cnt_ff != '0);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  a_addr_match: assert property ($rose(state_ff == ST_ACK_ADDR) |->
    $past(shift_ff[7:1]) == `I2C_DEV_ADDR) else $error("ack on foreign address");
  a_addr_ack: assert property (state_ff == ST_ACK_ADDR |-> sda_oe_ff)
    else $error("address not acknowledged");
  a_word_ack: assert property ($rose(state_ff == ST_ACK_RX) && $past(first_ff) |->
    ptr_ff == $past(shift_ff) && sda_oe_ff == addr_valid(ptr_ff))
    else $error("word address ack wrong");
  a_write_valid: assert property (wr_stb |-> addr_valid(ptr_ff) ##1 sda_oe_ff)
    else $error("write to invalid address");
  a_ptr_step: assert property ($rose(state_ff == ST_ACK_RX) && !$past(first_ff) |->
    ptr_ff == $past(ptr_ff) + 8'h01) else $error("pointer not advanced");
  a_ptr_hold: assert property (state_ff == ST_TX && nxt_state == ST_ACK_TX && sticky
    |=> $stable(ptr_ff)) else $error("pointer moved on angle high byte");
  a_msb_first: assert property (state_ff == ST_TX && scl_sync_ff && bit_cnt_ff != 4'h0
    |-> sda_oe_ff == ~shift_ff[7]) else $error("read bit order wrong");
  a_burn_limit: assert property ($changed(zcount_ff) |->
    zcount_ff == $past(zcount_ff) + 2'h1 && $past(magnet_detected_flag_in))
    else $error("zero burn count wrong");
  a_setup_once: assert property ($past(burned_ff) |->
    burned_ff && $stable(otp_ff.setup_word)) else $error("settings burnt twice");
  a_apply_delay: assert property ($changed(applied_ff) |-> $past(apply_cnt_ff) == CW'(1))
    else $error("settings applied early");
  a_forced_slow: assert property (applied_ff.setup_word.power_state_field != `POWER_NORMAL
    |=> decoded_ff.slow_filter == `SLOW_FILTER_16X) else $error("slow filter not forced");

  c_read_byte: cover property (state_ff == ST_TX ##[1:200] state_ff == ST_ACK_TX);
  c_write_byte: cover property (wr_stb);
  c_burn_zero: cover property ($changed(zcount_ff));
  c_reload: cover property (reload_ff == RL_TWO ##[1:1000] reload_ff == RL_IDLE);
endmodule // i2c_config_register_slave

// [tb/i2c_host_model.sv]
// Bus master model that drives the encoder register slave
`timescale 1ns/100ps
module i2c_host_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // ==========================================================
  // Bus conditions, four system clocks per phase
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #10;
  endtask
  task automatic start();
    cyc(2);
    sda_out = 1'b1;
    cyc(2);
    scl_out = 1'b1;
    cyc(4);
    sda_out = 1'b0;
    cyc(4);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    cyc(2);
    sda_out = 1'b0;
    cyc(2);
    scl_out = 1'b1;
    cyc(4);
    sda_out = 1'b1;
    cyc(4);
  endtask
  // Data moves only mid-way through the low phase
  task automatic bit_io(input logic b, output logic r);
    cyc(2);
    sda_out = b;
    cyc(2);
    scl_out = 1'b1;
    cyc(4);
    r = sda_in;
    scl_out = 1'b0;
  endtask
  // ==========================================================
  // Bytes
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(last, r);
  endtask
endmodule // i2c_host_model

// [tb/i2c_config_register_slave_test.sv]
// Self-checking bench for the encoder register slave
`timescale 1ns/100ps
`include "enc_i2c_defs.svh"
module i2c_config_register_slave_test;
  import enc_i2c_pkg::*;
  localparam int APPLY = 20;
  localparam logic [4:0] FTH_LSB [8] = '{5'h00, 5'h06, 5'h07, 5'h09, 5'h12, 5'h15, 5'h18, 5'h0A};
  localparam logic [11:0] ANG_IN [4] = '{12'h800, 12'hFFE, 12'h003, 12'h7FF};
  localparam logic [11:0] ANG_EX [4] = '{12'h800, 12'hFFE, 12'hFFE, 12'h7FF};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, m_sda, sda_oe, pend, ak, sda_o;
  wire logic sda = sda_oe ? (m_sda & sda_o) : m_sda;
  logic [11:0] raw = 12'h000, ang = 12'h800, ang_o;
  logic md = 1'b0, wk = 1'b0, st = 1'b0;
  logic [7:0] rs = 8'h39, acks;
  logic [7:0] dq [8];
  logic [7:0] rq [8];
  logic [1:0] zcnt;
  cfg_t cfg_o, ex;
  decoded_t dec_o;
  setup_word_t s;
  int error_cnt = 0, n_compared = 0;

  i2c_config_register_slave #(.APPLY_CYCLES(APPLY)) DUT (
    .sys_clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .raw_angle_in(raw), .scaled_angle_in(ang),
    .gain_level_in(rs), .magnitude_in({rs[3:0], rs}), .magnet_detected_flag_in(md),
    .field_weak_flag_in(wk), .field_strong_flag_in(st), .settings_out(cfg_o),
    .decoded_out(dec_o), .scaled_angle_out(ang_o), .zero_burn_count_out(zcnt),
    .apply_pending_out(pend));
  i2c_host_model M (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));

  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    #5_000_000;
    error_cnt++;
    conclude();
  end
  // ==========================================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic decoded_t dec(input cfg_t c);
    setup_word_t w;
    logic [3:0] q;
    w = c.setup_word;
    q = c.quadrature_resolution;
    dec.slow_filter = (w.power_state_field != 2'h0) ? 2'h0 : w.slow_filter_field;
    dec.fast_threshold_lsb = FTH_LSB[w.fast_filter_threshold];
    dec.positions = q[3] ? `QRES_MAX_POS : `QRES_MIN_POS << q[2:0];
  endfunction
  task automatic chk(input logic [37:0] g, input logic [37:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic settle();
    repeat (APPLY + 5) @(posedge clk);
    #10;
  endtask
  // Writes n bytes of dq from pointer p and leaves the bus open
  task automatic wr(input logic [7:0] p, input int n);
    acks = 8'h00;
    M.start();
    M.wr_byte({`I2C_DEV_ADDR, 1'b0}, ak);
    acks[0] = ak;
    M.wr_byte(p, ak);
    acks[1] = ak;
    for (int i = 0; i < n; i++) begin
      M.wr_byte(dq[i], ak);
      acks[i + 2] = ak;
    end
  endtask
  task automatic wrs(input logic [7:0] p, input int n);
    wr(p, n);
    M.stop();
    settle();
  endtask
  task automatic rd(input logic [7:0] p, input logic set, input int n);
    logic [7:0] b;
    if (set) begin
      wr(p, 0);
    end
    M.start();
    M.wr_byte({`I2C_DEV_ADDR, 1'b1}, ak);
    chk(ak, 1'b1);
    for (int i = 0; i < n; i++) begin
      M.rd_byte(i == n - 1, b);
      rq[i] = b;
    end
    M.stop();
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    #10;
    rst_n = 1'b1;
    settle();
    chk(cfg_o, 38'h0);
    M.start();
    M.wr_byte(8'h6E, ak);
    M.stop();
    chk(ak, 1'b0);
    ex = '0;
    rs = lfsr(rs);
    dq[0] = {4'h0, rs[3:0]};
    rs = lfsr(rs);
    dq[1] = rs;
    wrs(8'h01, 2);
    chk(acks, 8'h0F);
    ex.zero_position = {dq[0][3:0], dq[1]};
    rs = lfsr(rs);
    s = {rs[5:0], rs[7:4]};
    dq[0] = 8'hA5;
    dq[1] = {2'h0, s[9:4]};
    dq[2] = {4'h0, s[3:0]};
    rs = lfsr(rs);
    dq[3] = {4'h0, rs[3:0]};
    dq[4] = rs | 8'h01;
    wr(8'h06, 5);
    chk(pend, 1'b1);
    chk(cfg_o.press_threshold, 8'h00);
    M.stop();
    settle();
    chk(acks, 8'h79);
    ex.setup_word = s;
    ex.quadrature_resolution = dq[3][3:0];
    ex.press_threshold = dq[4];
    chk(cfg_o, ex);
    chk(dec_o, dec(ex));
    rd(8'h01, 1'b1, 3);
    chk(rq[0], {4'h0, ex.zero_position[11:8]});
    chk(rq[1], ex.zero_position[7:0]);
    chk(rq[2], 8'h00);
    rd(8'h07, 1'b1, 1);
    chk(rq[0], {2'h0, s[9:4]});
    rd(8'h00, 1'b0, 1);
    chk(rq[0], {4'h0, s[3:0]});
    rs = lfsr(rs);
    raw = {rs[3:0], rs};
    {md, wk, st} = rs[2:0];
    rd(`REG_RAW_HI, 1'b1, 3);
    for (int i = 0; i < 3; i++) begin
      chk(rq[i], {4'h0, raw[11:8]});
    end
    rd(`REG_FLAGS, 1'b1, 1);
    chk(rq[0], {2'h0, md, wk, st, 3'h0});
    rd(`REG_GAIN, 1'b1, 3);
    chk(rq[0], rs);
    chk(rq[1], {4'h0, rs[3:0]});
    chk(rq[2], {4'h0, rs[3:0]});
    for (int c = 0; c < 16; c++) begin
      s = {c[0], c[2:0], c[1:0], c[3:2], c[3], c[3] & c[2]};
      dq[0] = {2'h0, s[9:4]};
      dq[1] = {4'h0, s[3:0]};
      dq[2] = c[7:0];
      wrs(8'h07, 3);
      ex.setup_word = s;
      ex.quadrature_resolution = c[3:0];
      chk(dec_o, dec(ex));
    end
    chk(cfg_o, ex);
    for (int k = 0; k < 5; k++) begin
      md = (k != 0);
      dq[0] = `CMD_BURN_ZERO;
      wrs(`REG_CMD, 1);
      chk(zcnt, (k > 3) ? 2'h3 : k[1:0]);
    end
    dq[0] = 8'h55;
    wrs(`REG_CMD, 1);
    chk(cfg_o, ex);
    rd(`REG_ZCOUNT, 1'b1, 1);
    chk(rq[0], 8'h03);
    dq[0] = `CMD_BURN_SETUP;
    wrs(`REG_CMD, 1);
    dq[0] = 8'h00;
    dq[1] = 8'h00;
    dq[2] = 8'h00;
    wrs(8'h07, 3);
    chk(cfg_o.setup_word, 10'h000);
    dq[0] = `CMD_BURN_SETUP;
    wrs(`REG_CMD, 1);
    for (int j = 0; j < 3; j++) begin
      dq[0] = (j == 0) ? `CMD_RELOAD_A : (j == 1) ? `CMD_RELOAD_B : `CMD_RELOAD_C;
      wrs(`REG_CMD, 1);
    end
    chk(cfg_o, ex);
    for (int h = 0; h < 4; h++) begin
      ang = ANG_IN[h];
      repeat (4) @(posedge clk);
      #10;
      chk(ang_o, ANG_EX[h]);
    end
    rd(`REG_ANG_HI, 1'b1, 2);
    chk(rq[0], {4'h0, ANG_EX[3][11:8]});
    chk(rq[1], {4'h0, ANG_EX[3][11:8]});
    conclude();
  end
endmodule // i2c_config_register_slave_test
